// ### rtl/tdm_pkg.sv
// Package for the transmit drive activity monitor
package tdm_pkg;

    // Inactivity window length in bit periods
    localparam int unsigned WINDOW_BITS = 128;
    // Width of the inactivity counter (holds 0..WINDOW_BITS)
    localparam int unsigned CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
    localparam logic [CNT_W-1:0] CNT_LIMIT = 8'h80;

    // Monitoring source select encoding
    typedef enum logic {
        TDM_SRC_EXTERNAL = 1'b0,
        TDM_SRC_INTERNAL = 1'b1
    } tdm_src_e;

    // One pair of line polarity observations
    typedef struct packed {
        logic pos;  // Positive rail high
        logic neg;  // Negative rail high
    } tdm_rails_s;

endpackage

// ### rtl/tdm_monitor.sv
// Transmit drive activity monitor for one line channel
`timescale 1ns/10ps

module tdm_monitor
    import tdm_pkg::*;
(
    input  wire logic       clk,             // System clock, 200 MHz
    input  wire logic       reset,           // Async reset, active high
    input  wire logic       bit_tick,        // One pulse per bit period
    input  wire logic       src_internal,    // 1 = internal tap source
    input  wire logic       line_out_pos,    // Internal tap, positive out
    input  wire logic       line_out_neg,    // Internal tap, negative out
    input  wire logic       monitor_pos_in,  // External monitor, positive
    input  wire logic       monitor_neg_in,  // External monitor, negative
    output logic            drive_fault_out  // High = no recent activity
);

    // ------------------------------------------------------------
    // Input synchronisers for the external monitor pins
    // ------------------------------------------------------------
    tdm_rails_s ext_meta_reg;   // First stage, read only by second
    tdm_rails_s ext_meta_next;  // Pins as they stand this cycle
    tdm_rails_s ext_sync_reg;   // Second stage, safe to use
    tdm_rails_s ext_sync_next;  // First stage moved one step on

    // Next values: pins enter stage one, stage one moves to two.
    // The pins are not tied to clk, so stage one may go metastable;
    // nothing but stage two reads it.
    always_comb begin
        ext_meta_next = '{pos: monitor_pos_in, neg: monitor_neg_in};
        ext_sync_next = ext_meta_reg;
    end

    // Two-stage capture of pins from outside the clock domain
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ext_meta_reg <= '0;
            ext_sync_reg <= '0;
        end else begin
            ext_meta_reg <= ext_meta_next;
            ext_sync_reg <= ext_sync_next;
        end
    end

    // ------------------------------------------------------------
    // Source selection and pulse detection
    // ------------------------------------------------------------
    tdm_src_e   src_sel;        // Selected monitoring source
    tdm_rails_s obs;            // Rails seen by the monitor
    logic       pulse_seen;     // A bipolar pulse is present now
    logic       pulse_hold_reg; // Pulse caught since last bit tick
    logic       pulse_hold_next;

    assign src_sel = src_internal ? TDM_SRC_INTERNAL : TDM_SRC_EXTERNAL;

    // Pick rails; external pins have no path when internal selected.
    // The count is kept across a change of source, so a switch never
    // hides a quiet window that began on the other path.
    always_comb begin
        unique case (src_sel)
            TDM_SRC_INTERNAL: obs = '{pos: line_out_pos,
                                      neg: line_out_neg};
            TDM_SRC_EXTERNAL: obs = ext_sync_reg;
        endcase
    end

    // Either polarity counts: rails differ in one direction or other
    assign pulse_seen = obs.pos ^ obs.neg;

    // Stretch short pulses so none is lost between bit ticks.
    // A tick clears the stretch; a pulse in the tick cycle itself is
    // caught by the counter logic directly, so none falls in the gap.
    always_comb begin
        if (bit_tick) begin
            pulse_hold_next = 1'b0;
        end else begin
            pulse_hold_next = pulse_hold_reg | pulse_seen;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pulse_hold_reg <= 1'b0;
        end else begin
            pulse_hold_reg <= pulse_hold_next;
        end
    end

    // ------------------------------------------------------------
    // Inactivity counter and fault flag
    // ------------------------------------------------------------
    logic [CNT_W-1:0] quiet_cnt_reg;  // Bit periods without a pulse
    logic [CNT_W-1:0] quiet_cnt_next;
    logic             fault_reg;      // Registered fault output
    logic             fault_next;
    logic             activity;       // Pulse within this bit period

    assign activity = pulse_hold_reg | pulse_seen;

    // Count bit periods, clear on any pulse, saturate at the limit
    always_comb begin
        quiet_cnt_next = quiet_cnt_reg;
        fault_next     = fault_reg;
        if (bit_tick) begin
            if (activity) begin
                quiet_cnt_next = CNT_RESET;
                fault_next     = 1'b0;
            end else if (quiet_cnt_reg < CNT_LIMIT) begin
                quiet_cnt_next = quiet_cnt_reg + 8'h01;
                fault_next     = (quiet_cnt_reg + 8'h01)
                                 == CNT_LIMIT;
            end else begin
                fault_next     = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            quiet_cnt_reg <= CNT_RESET;
            fault_reg     <= 1'b0;
        end else begin
            quiet_cnt_reg <= quiet_cnt_next;
            fault_reg     <= fault_next;
        end
    end

    assign drive_fault_out = fault_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_fault_at_limit;
        @(posedge clk) disable iff (reset)
        (bit_tick && !activity && quiet_cnt_reg == CNT_LIMIT - 8'h01)
            |=> drive_fault_out;
    endproperty
    a_fault_at_limit: assert property (p_fault_at_limit)
        else $error("fault not raised after 128 quiet bits");

    property p_clear_on_pulse;
        @(posedge clk) disable iff (reset)
        (bit_tick && activity)
            |=> !drive_fault_out && quiet_cnt_reg == CNT_RESET;
    endproperty
    a_clear_on_pulse: assert property (p_clear_on_pulse)
        else $error("fault or counter not cleared by a pulse");

    property p_no_early_fault;
        @(posedge clk) disable iff (reset)
        (quiet_cnt_reg < CNT_LIMIT) |-> !drive_fault_out;
    endproperty
    a_no_early_fault: assert property (p_no_early_fault)
        else $error("fault raised before 128 quiet bits");

    property p_count_step;
        @(posedge clk) disable iff (reset)
        (bit_tick && !activity && quiet_cnt_reg < CNT_LIMIT)
            |=> quiet_cnt_reg == $past(quiet_cnt_reg) + 8'h01;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("quiet counter did not advance");

    property p_ext_ignored;
        @(posedge clk) disable iff (reset)
        src_internal |-> pulse_seen == (line_out_pos ^ line_out_neg);
    endproperty
    a_ext_ignored: assert property (p_ext_ignored)
        else $error("external pins influence internal monitoring");

    property p_hold_catch;
        @(posedge clk) disable iff (reset)
        (pulse_seen && !bit_tick) |=> pulse_hold_reg;
    endproperty
    a_hold_catch: assert property (p_hold_catch)
        else $error("pulse between ticks was lost");

    // A raised fault stays up while bit periods pass quietly
    property p_fault_stands;
        @(posedge clk) disable iff (reset)
        (bit_tick && !activity && drive_fault_out) |=> drive_fault_out;
    endproperty
    a_fault_stands: assert property (p_fault_stands)
        else $error("fault dropped with no pulse seen");

    // A fault only stands with a full quiet window behind it
    property p_fault_only_full;
        @(posedge clk) disable iff (reset)
        drive_fault_out |-> quiet_cnt_reg == CNT_LIMIT;
    endproperty
    a_fault_only_full: assert property (p_fault_only_full)
        else $error("fault high without a full quiet window");

    // Counter and fault move only on a bit tick
    property p_tick_only;
        @(posedge clk) disable iff (reset)
        !bit_tick |=> $stable(quiet_cnt_reg) && $stable(drive_fault_out);
    endproperty
    a_tick_only: assert property (p_tick_only)
        else $error("counter or fault moved between bit ticks");

    // External source reads the synchronised monitor pins
    property p_ext_path;
        @(posedge clk) disable iff (reset)
        !src_internal
            |-> pulse_seen == (ext_sync_reg.pos ^ ext_sync_reg.neg);
    endproperty
    a_ext_path: assert property (p_ext_path)
        else $error("external source not taken from monitor pins");

    // Counter never runs past the window length
    property p_cnt_bounded;
        @(posedge clk) disable iff (reset)
        quiet_cnt_reg <= CNT_LIMIT;
    endproperty
    a_cnt_bounded: assert property (p_cnt_bounded)
        else $error("quiet counter ran past the window");

endmodule

// ### dv/tdm_line_drv.sv
// Partner model: transmit line driver with wired-back monitor pins
`timescale 1ns/10ps

module tdm_line_drv (
    input  wire logic clk,            // Bench clock
    input  wire logic send_pos,       // Request a positive pulse
    input  wire logic send_neg,       // Request a negative pulse
    input  wire logic tap_on,         // Low keeps the internal tap quiet
    output logic      line_out_pos,   // Driver positive output
    output logic      line_out_neg,   // Driver negative output
    output logic      monitor_pos_in, // Wired-back positive rail
    output logic      monitor_neg_in  // Wired-back negative rail
);
    // One-cycle pulses; rails equal means no pulse on the line
    always_ff @(posedge clk) begin
        monitor_pos_in <= send_pos;
        monitor_neg_in <= send_neg;
        line_out_pos   <= send_pos & tap_on;
        line_out_neg   <= send_neg & tap_on;
    end
endmodule

// ### dv/tb.sv
// Testbench for the transmit drive activity monitor
`timescale 1ns/10ps

module tb;
    import tdm_pkg::*;
    // ------------------------------------------------
    // Signals and counters
    // ------------------------------------------------
    logic clk, reset, bit_tick, src_internal;     // Design controls
    logic send_pos, send_neg, tap_on;             // Partner controls
    logic line_out_pos, line_out_neg;             // Internal tap
    logic monitor_pos_in, monitor_neg_in;         // External pins
    logic drive_fault_out;                        // Fault flag
    int   errors, compares;                       // Report counters

    tdm_line_drv drv_u (.clk, .send_pos, .send_neg, .tap_on,
        .line_out_pos, .line_out_neg, .monitor_pos_in, .monitor_neg_in);
    tdm_monitor dut_u (.clk, .reset, .bit_tick, .src_internal,
        .line_out_pos, .line_out_neg, .monitor_pos_in, .monitor_neg_in,
        .drive_fault_out);

    // Free-running 200 MHz clock
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    // ------------------------------------------------
    // Helper tasks
    // ------------------------------------------------
    task automatic chk(input logic exp);
        compares++;
        if (drive_fault_out !== exp) begin
            errors++;
            $display("MISMATCH at %0t: fault %b not %b", $time,
                drive_fault_out, exp);
        end
    endtask

    // Run n back-to-back ticks, then let the flag settle
    task automatic ticks(input int n);
        repeat (n) @(posedge clk) bit_tick <= 1'h1;
        @(posedge clk) bit_tick <= 1'h0;
        @(posedge clk);
        #1;
    endtask

    // One line pulse, then room for the pin synchroniser
    task automatic pulse(input logic p, input logic n);
        @(posedge clk) send_pos <= p;
        send_neg <= n;
        @(posedge clk) send_pos <= 1'h0;
        send_neg <= 1'h0;
        repeat (4) @(posedge clk);
    endtask

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    // Window edge: 127 quiet periods pass, the 128th faults
    task automatic scn_window;
        ticks(127);
        chk(1'h0);
        ticks(1);
        chk(1'h1);
    endtask

    // Both rails high is not a pulse
    task automatic scn_both_rails;
        pulse(1'h1, 1'h1);
        ticks(1);
        chk(1'h1);
    endtask

    // Internal tap pulse clears, then a full window faults again
    task automatic scn_internal_clear;
        pulse(1'h1, 1'h0);
        ticks(1);
        chk(1'h0);
        ticks(127);
        chk(1'h0);
        ticks(1);
        chk(1'h1);
    endtask

    // Internal source: pulse seen only on external pins
    task automatic scn_ext_ignored;
        @(posedge clk) tap_on <= 1'h0;
        pulse(1'h0, 1'h1);
        ticks(1);
        chk(1'h1);
    endtask

    // External source: negative pulse on the pins clears it
    task automatic scn_ext_clear;
        @(posedge clk) src_internal <= 1'h0;
        pulse(1'h0, 1'h1);
        ticks(1);
        chk(1'h0);
    endtask

    task automatic wrap_up;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        reset <= 1'h1;
        bit_tick <= 1'h0;
        {send_pos, send_neg} <= 2'h0;
        {src_internal, tap_on} <= 2'h3;
        errors = 0;
        compares = 0;
        repeat (5) @(posedge clk);
        reset <= 1'h0;
        scn_window();
        scn_both_rails();
        scn_internal_clear();
        scn_ext_ignored();
        scn_ext_clear();
        wrap_up();
    end
endmodule
